// file: src/itc_top.sv
// module: contact input conditioning with function routing and counter
`timescale 1ns/1ps
`default_nettype none
module itc_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] contact_n_i,
  input wire logic [31:0] count_restore_i,
  input wire logic count_restore_valid_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [7:0] input_level_o,
  output logic [49:0] func_active_o,
  output logic motor_group_o,
  output logic set_count_reached_o,
  output logic designated_count_reached_o,
  output logic [31:0] count_save_o,
  output logic irq_o
);
  localparam int unsigned NI = itc_pkg::N_IN;
  localparam int unsigned FW = itc_pkg::FUNC_W;

  logic [5:0] pol_lo;
  logic [1:0] pol_hi;
  logic [15:0] filt_time;
  logic group_sel;
  logic [NI*FW-1:0] func_sel;
  logic [15:0] dly [itc_pkg::N_DELAYED];
  logic [31:0] set_tgt, des_tgt, count;
  logic [2:0] irq_st, irq_mask;
  logic [31:0] rdata;
  logic ack, restored;
  logic group_q;
  logic [5:0] tick_cnt;
  logic tick;

  logic [5:0] next_pol_lo;
  logic [1:0] next_pol_hi;
  logic [15:0] next_filt_time;
  logic next_group_sel;
  logic [NI*FW-1:0] next_func_sel;
  logic [15:0] next_dly [itc_pkg::N_DELAYED];
  logic [31:0] next_set_tgt, next_des_tgt, next_count;
  logic [2:0] next_irq_st, next_irq_mask;
  logic [31:0] next_rdata;
  logic next_ack, next_restored, next_group_q;
  logic [5:0] next_tick_cnt;

  logic [NI-1:0] lvl, rise;
  logic [49:0] fact;
  logic cnt_pulse, cnt_clr, override, eff_group;
  logic set_hit, des_hit, wr, rd;
  logic [7:0] adr;
  logic [31:0] wmask;

  function automatic logic [FW-1:0] sel_of(input logic [NI*FW-1:0] v,
                                           input int unsigned i);
    sel_of = v[i*FW +: FW];
  endfunction : sel_of

  // 1 us enable sets filter and delay units
  assign tick = (tick_cnt == 6'((itc_pkg::TICK_CYC) - 1));

  genvar g;
  generate
    for (g = 0; g < NI; g++) begin : g_ch
      itc_chan_if cif ();
      assign cif.raw = ~contact_n_i[g]; // shorted pin is low: active 1
      if (g < itc_pkg::POL_LO_W) begin : g_lo
        assign cif.invert = pol_lo[g];
      end else begin : g_hi
        assign cif.invert = pol_hi[g - itc_pkg::POL_LO_W];
      end
      assign cif.filt_ticks = filt_time;
      if (g < itc_pkg::N_DELAYED) begin : g_d
        assign cif.dly_ticks = dly[g];
      end else begin : g_nd
        assign cif.dly_ticks = 16'h0000;
      end
      assign cif.tick = tick;
      itc_chan #(.HAS_DELAY(g < itc_pkg::N_DELAYED)) u_ch (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ch(cif)
      );
      assign lvl[g] = cif.level;
      assign rise[g] = cif.rise;
    end
  endgenerate

  // function routing; selectors at 50 or above are ignored
  always_comb begin
    logic [FW-1:0] s;
    s = '0;
    fact = '0;
    for (int i = 0; i < NI; i++) begin
      s = sel_of(func_sel, i);
      if (s < FW'(itc_pkg::N_FUNC)) begin
        fact[s] = fact[s] | lvl[i];
      end
    end
  end

  // counting honours only the pulse-capable input
  assign cnt_pulse = rise[itc_pkg::PULSE_IN] &
    (sel_of(func_sel, itc_pkg::PULSE_IN) == itc_pkg::FUNC_COUNT_IN);
  assign cnt_clr = fact[itc_pkg::FUNC_COUNT_RST];
  assign override = fact[itc_pkg::FUNC_GROUP_SEL];
  assign eff_group = override | group_sel;
  assign set_hit = (count == set_tgt);
  assign des_hit = (count == des_tgt);

  assign adr = wb_adr_i[7:0];
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~ack;
  assign rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack;
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{wb_sel_i[b]}};
    end
  end

  always_comb begin
    next_tick_cnt = tick ? 6'h00 : tick_cnt + 6'h01;
    next_pol_lo = pol_lo;
    next_pol_hi = pol_hi;
    next_filt_time = filt_time;
    next_group_sel = group_sel;
    next_func_sel = func_sel;
    next_dly = dly;
    next_set_tgt = set_tgt;
    next_des_tgt = des_tgt;
    next_irq_mask = irq_mask;
    next_ack = wb_cyc_i & wb_stb_i & ~ack;
    next_rdata = rdata;
    next_restored = 1'b1;
    next_group_q = eff_group;
    next_count = count;
    if (!restored && count_restore_valid_i) begin
      next_count = count_restore_i;
    end else if (cnt_clr) begin
      next_count = 32'h0000_0000;
    end else if (cnt_pulse && !set_hit) begin
      next_count = count + 32'h0000_0001;
    end
    next_irq_st = irq_st;
    if (rd && adr == itc_pkg::ADR_IRQ_ST) begin
      next_irq_st = 3'h0;
    end
    // set after clear so an event in the read cycle survives
    if (set_hit && !set_reached_q) next_irq_st[itc_pkg::IRQ_SET_HIT] = 1'b1;
    if (des_hit && !des_reached_q) next_irq_st[itc_pkg::IRQ_DES_HIT] = 1'b1;
    if (eff_group != group_q) next_irq_st[itc_pkg::IRQ_GROUP_CHG] = 1'b1;
    if (wr) begin
      unique case (adr)
        itc_pkg::ADR_POL_LO: next_pol_lo = wb_sel_i[0] ? wb_dat_i[5:0] : pol_lo;
        itc_pkg::ADR_POL_HI: next_pol_hi = wb_sel_i[0] ? wb_dat_i[1:0] : pol_hi;
        itc_pkg::ADR_FILT: next_filt_time =
          (filt_time & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
        itc_pkg::ADR_GROUP: next_group_sel =
          wb_sel_i[0] ? wb_dat_i[0] : group_sel;
        itc_pkg::ADR_FUNC_LO: next_func_sel[29:0] =
          (func_sel[29:0] & ~wmask[29:0]) | (wb_dat_i[29:0] & wmask[29:0]);
        itc_pkg::ADR_FUNC_HI: next_func_sel[47:30] =
          (func_sel[47:30] & ~wmask[17:0]) | (wb_dat_i[17:0] & wmask[17:0]);
        itc_pkg::ADR_DLY0: next_dly[0] =
          (dly[0] & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
        itc_pkg::ADR_DLY1: next_dly[1] =
          (dly[1] & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
        itc_pkg::ADR_DLY2: next_dly[2] =
          (dly[2] & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
        itc_pkg::ADR_SET_TGT: next_set_tgt =
          (set_tgt & ~wmask) | (wb_dat_i & wmask);
        itc_pkg::ADR_DES_TGT: next_des_tgt =
          (des_tgt & ~wmask) | (wb_dat_i & wmask);
        itc_pkg::ADR_IRQ_MASK: next_irq_mask =
          wb_sel_i[0] ? wb_dat_i[2:0] : irq_mask;
        default: next_ack = wb_cyc_i & wb_stb_i & ~ack;
      endcase
    end
    if (rd) begin
      unique case (adr)
        itc_pkg::ADR_POL_LO: next_rdata = {26'h0, pol_lo};
        itc_pkg::ADR_POL_HI: next_rdata = {30'h0, pol_hi};
        itc_pkg::ADR_FILT: next_rdata = {16'h0, filt_time};
        itc_pkg::ADR_GROUP: next_rdata = {31'h0, group_sel};
        itc_pkg::ADR_FUNC_LO: next_rdata = {2'h0, func_sel[29:0]};
        itc_pkg::ADR_FUNC_HI: next_rdata = {14'h0, func_sel[47:30]};
        itc_pkg::ADR_DLY0: next_rdata = {16'h0, dly[0]};
        itc_pkg::ADR_DLY1: next_rdata = {16'h0, dly[1]};
        itc_pkg::ADR_DLY2: next_rdata = {16'h0, dly[2]};
        itc_pkg::ADR_SET_TGT: next_rdata = set_tgt;
        itc_pkg::ADR_DES_TGT: next_rdata = des_tgt;
        itc_pkg::ADR_COUNT: next_rdata = count;
        itc_pkg::ADR_STATE: next_rdata = {20'h0, set_hit, des_hit,
                                          eff_group, override, lvl};
        itc_pkg::ADR_IRQ_ST: next_rdata = {29'h0, irq_st};
        itc_pkg::ADR_IRQ_MASK: next_rdata = {29'h0, irq_mask};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  logic set_reached_q, des_reached_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt <= 6'h00;
      pol_lo <= 6'h00;
      pol_hi <= 2'h0;
      filt_time <= itc_pkg::FILT_RST;
      group_sel <= 1'b0;
      func_sel <= '0;
      dly <= '{default: 16'h0000};
      set_tgt <= itc_pkg::SET_TGT_RST;
      des_tgt <= itc_pkg::SET_TGT_RST;
      count <= 32'h0000_0000;
      irq_st <= 3'h0;
      irq_mask <= 3'h0;
      rdata <= 32'h0000_0000;
      ack <= 1'b0;
      restored <= 1'b0;
      group_q <= 1'b0;
      set_reached_q <= 1'b0;
      des_reached_q <= 1'b0;
    end else begin
      tick_cnt <= next_tick_cnt;
      pol_lo <= next_pol_lo;
      pol_hi <= next_pol_hi;
      filt_time <= next_filt_time;
      group_sel <= next_group_sel;
      func_sel <= next_func_sel;
      dly <= next_dly;
      set_tgt <= next_set_tgt;
      des_tgt <= next_des_tgt;
      count <= next_count;
      irq_st <= next_irq_st;
      irq_mask <= next_irq_mask;
      rdata <= next_rdata;
      ack <= next_ack;
      restored <= next_restored;
      group_q <= next_group_q;
      set_reached_q <= set_hit;
      des_reached_q <= des_hit;
    end
  end

  assign wb_dat_o = rdata;
  assign wb_ack_o = ack;
  assign input_level_o = lvl;
  assign func_active_o = fact;
  assign motor_group_o = group_q;
  assign set_count_reached_o = set_reached_q;
  assign designated_count_reached_o = des_reached_q;
  assign count_save_o = count; // external store keeps it over power loss
  assign irq_o = |(irq_st & irq_mask);
endmodule : itc_top
`default_nettype wire

// file: src/itc_pkg.sv
// package: register map, field positions and timing constants for input conditioning
package itc_pkg;
  localparam int unsigned N_IN = 8;
  localparam int unsigned N_DELAYED = 3;
  localparam int unsigned FUNC_W = 6;
  localparam int unsigned N_FUNC = 50;
  localparam int unsigned CNT_W = 32;
  localparam int unsigned PULSE_IN = 5;
  localparam logic [5:0] FUNC_GROUP_SEL = 6'h29;
  localparam logic [5:0] FUNC_COUNT_IN = 6'h19;
  localparam logic [5:0] FUNC_COUNT_RST = 6'h1A;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned TICK_US = 1;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000000 * TICK_US;
  localparam logic [7:0] ADR_POL_LO = 8'h00;
  localparam logic [7:0] ADR_POL_HI = 8'h04;
  localparam logic [7:0] ADR_FILT = 8'h08;
  localparam logic [7:0] ADR_GROUP = 8'h0C;
  localparam logic [7:0] ADR_FUNC_LO = 8'h10;
  localparam logic [7:0] ADR_FUNC_HI = 8'h14;
  localparam logic [7:0] ADR_DLY0 = 8'h18;
  localparam logic [7:0] ADR_DLY1 = 8'h1C;
  localparam logic [7:0] ADR_DLY2 = 8'h20;
  localparam logic [7:0] ADR_SET_TGT = 8'h24;
  localparam logic [7:0] ADR_DES_TGT = 8'h28;
  localparam logic [7:0] ADR_COUNT = 8'h2C;
  localparam logic [7:0] ADR_STATE = 8'h30;
  localparam logic [7:0] ADR_IRQ_ST = 8'h34;
  localparam logic [7:0] ADR_IRQ_MASK = 8'h38;
  localparam int unsigned POL_LO_W = 6;
  localparam int unsigned POL_HI_W = 2;
  localparam int unsigned IRQ_SET_HIT = 0;
  localparam int unsigned IRQ_DES_HIT = 1;
  localparam int unsigned IRQ_GROUP_CHG = 2;
  localparam logic [15:0] FILT_RST = 16'h000A;
  localparam logic [31:0] SET_TGT_RST = 32'h0000_03E8;
endpackage : itc_pkg

// file: src/itc_chan_if.sv
// interface: per-input conditioning settings and result
`timescale 1ns/1ps
`default_nettype none
interface itc_chan_if;
  logic raw;
  logic invert;
  logic [15:0] filt_ticks;
  logic [15:0] dly_ticks;
  logic tick;
  logic level;
  logic rise;
  modport top (output raw, output invert, output filt_ticks,
    output dly_ticks, output tick, input level, input rise);
  modport chan (input raw, input invert, input filt_ticks,
    input dly_ticks, input tick, output level, output rise);
endinterface : itc_chan_if
`default_nettype wire

// file: src/itc_chan.sv
// module: one input channel - sync, polarity, filter, optional delay
`timescale 1ns/1ps
`default_nettype none
module itc_chan #(
  parameter bit HAS_DELAY = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  itc_chan_if.chan ch
);
  logic sync_a, sync_b, filt, dly_out, prev;
  logic [15:0] fcnt, dcnt;
  logic next_filt, next_dly_out, next_prev;
  logic [15:0] next_fcnt, next_dcnt;
  logic pol;

  // invert after sync so polarity never touches the first stage
  assign pol = sync_b ^ ch.invert;

  always_comb begin
    next_filt = filt;
    next_fcnt = fcnt;
    if (pol == filt) begin
      next_fcnt = 16'h0000;
    end else if (ch.tick) begin
      if (fcnt >= ch.filt_ticks) begin
        next_filt = pol;
        next_fcnt = 16'h0000;
      end else begin
        next_fcnt = fcnt + 16'h0001;
      end
    end
    next_dly_out = dly_out;
    next_dcnt = dcnt;
    if (!HAS_DELAY) begin
      next_dly_out = filt;
      next_dcnt = 16'h0000;
    end else if (filt == dly_out) begin
      next_dcnt = 16'h0000;
    end else if (ch.tick) begin
      if (dcnt >= ch.dly_ticks) begin
        next_dly_out = filt;
        next_dcnt = 16'h0000;
      end else begin
        next_dcnt = dcnt + 16'h0001;
      end
    end
    next_prev = dly_out;
  end

  always_ff @(posedge clk_i) begin
    sync_a <= ch.raw;
    sync_b <= sync_a;
    if (rst_i) begin
      filt <= 1'b0;
      fcnt <= 16'h0000;
      dly_out <= 1'b0;
      dcnt <= 16'h0000;
      prev <= 1'b0;
    end else begin
      filt <= next_filt;
      fcnt <= next_fcnt;
      dly_out <= next_dly_out;
      dcnt <= next_dcnt;
      prev <= next_prev;
    end
  end

  assign ch.level = dly_out;
  assign ch.rise = dly_out & ~prev;
endmodule : itc_chan
`default_nettype wire

// file: tb/itc_contacts.sv
// model: dry contacts that short input terminals to the common return
`timescale 1ns/1ps
`default_nettype none
module itc_contacts (
  input wire logic [7:0] closed_i,
  output logic [7:0] contact_n_o
);
  // an open terminal is pulled up by the internal supply, so it reads high
  assign contact_n_o = ~closed_i;
endmodule : itc_contacts
`default_nettype wire

// file: tb/itc_top_monitor.sv
// checker: assertions on the ports of the input conditioning block
`timescale 1ns/1ps
`default_nettype none
module itc_top_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [7:0] input_level_o,
  input wire logic [49:0] func_active_o,
  input wire logic motor_group_o,
  input wire logic set_count_reached_o,
  input wire logic [31:0] count_save_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  chk_ack_pulse:
    assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held over one cycle");
  chk_ack_answer:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  chk_ack_cause:
    assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  chk_reset_quiet:
    assert property ($past(rst_i) |-> !wb_ack_o && !irq_o && !motor_group_o
      && !set_count_reached_o && input_level_o == 8'h00
      && count_save_o == 32'h0)
    else $error("outputs not idle after reset");
  chk_func_route:
    assert property ($countones(func_active_o) <= $countones(input_level_o))
    else $error("more functions active than inputs");
  chk_group_override:
    assert property (func_active_o[itc_pkg::FUNC_GROUP_SEL] |=> motor_group_o)
    else $error("group input did not override register");
  chk_count_source:
    assert property (count_save_o == $past(count_save_o) + 32'h1
      && !$past(rst_i, 2) |-> input_level_o[itc_pkg::PULSE_IN])
    else $error("count advanced without the pulse input");
  chk_count_hold:
    assert property (set_count_reached_o
      && !func_active_o[itc_pkg::FUNC_COUNT_RST] |=> $stable(count_save_o))
    else $error("count moved past target");
  chk_reached_hold:
    assert property (set_count_reached_o
      && !func_active_o[itc_pkg::FUNC_COUNT_RST] |=> set_count_reached_o)
    else $error("reached flag dropped");
endmodule : itc_top_monitor

bind itc_top itc_top_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .input_level_o(input_level_o), .func_active_o(func_active_o),
  .motor_group_o(motor_group_o), .set_count_reached_o(set_count_reached_o),
  .count_save_o(count_save_o), .irq_o(irq_o));
`default_nettype wire

// file: tb/tb_input_terminal_conditioning.sv
// testbench: random and corner-case checks of input conditioning
`timescale 1ns/1ps
`default_nettype none
module tb_input_terminal_conditioning;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] closed = 8'h00;
  logic [7:0] contact_n;
  logic [31:0] rst_cnt = 32'h0, wb_adr_i = 32'h0, wb_dat_i = 32'h0;
  logic rst_vld = 1'b0, wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic [31:0] wb_dat_o, count_save_o, q;
  logic [7:0] input_level_o;
  logic [49:0] func_active_o;
  logic wb_ack_o, motor_group_o, set_hit, des_hit, irq_o;
  int errors = 0;
  int n_checks = 0;
  int c;
  logic [7:0] ra [5] = '{itc_pkg::ADR_FILT, itc_pkg::ADR_SET_TGT,
    itc_pkg::ADR_DES_TGT, itc_pkg::ADR_COUNT, 8'h3C};
  logic [31:0] re [5] = '{32'(itc_pkg::FILT_RST), itc_pkg::SET_TGT_RST,
    32'h3E8, 32'h0, 32'h0};
  always #12.5 clk_i = ~clk_i;
  itc_contacts u_sw (.closed_i(closed), .contact_n_o(contact_n));
  itc_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .contact_n_i(contact_n),
    .count_restore_i(rst_cnt), .count_restore_valid_i(rst_vld),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(4'hF),
    .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .input_level_o(input_level_o),
    .func_active_o(func_active_o), .motor_group_o(motor_group_o),
    .set_count_reached_o(set_hit), .designated_count_reached_o(des_hit),
    .count_save_o(count_save_o), .irq_o(irq_o));
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_adr_i <= {24'h000000, a};
    wb_we_i <= w;
    wb_dat_i <= d;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      errors++;
      end_sim();
    end
  endtask : wb
  task automatic settle(input logic [7:0] e);
    c = 0;
    while (input_level_o !== e && c < 3000) begin
      @(posedge clk_i);
      c++;
    end
    cmp(64'(input_level_o), 64'(e));
  endtask : settle
  // counts cycles until one conditioned level moves, giving up at lim
  task automatic lat(input int i, input int lim);
    logic v;
    v = input_level_o[i];
    c = 0;
    while (input_level_o[i] === v && c < lim) begin
      @(posedge clk_i);
      c++;
    end
  endtask : lat
  task automatic pulse(input int i);
    closed[i] <= 1'b1;
    repeat (120) @(posedge clk_i);
    closed[i] <= 1'b0;
    repeat (120) @(posedge clk_i);
  endtask : pulse
  function automatic logic [7:0] exp_lvl(input logic [7:0] sh,
      input logic [7:0] p);
    return sh ^ p;
  endfunction : exp_lvl
  function automatic logic [31:0] exp_cnt(input int n, input int tgt);
    return 32'((n < tgt) ? n : tgt);
  endfunction : exp_cnt
  initial begin
    repeat (90000) @(posedge clk_i);
    errors++;
    end_sim();
  end
  initial begin
    logic [7:0] pol;
    logic [31:0] v;
    void'($urandom(32'h31B6));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(8'h3C, 1'b1, 32'hFFFFFFFF);
    for (int k = 0; k < 5; k++) begin
      wb(ra[k], 1'b0, 32'h0);
      cmp(64'(q), 64'(re[k]));
    end
    $display("test reset done");
    wb(itc_pkg::ADR_FILT, 1'b1, 32'h0);
    for (int k = 0; k < 6; k++) begin
      pol = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($urandom);
      closed <= 8'($urandom);
      wb(itc_pkg::ADR_POL_LO, 1'b1, {26'h0, pol[5:0]});
      wb(itc_pkg::ADR_POL_HI, 1'b1, {30'h0, pol[7:6]});
      settle(exp_lvl(closed, pol));
    end
    wb(itc_pkg::ADR_POL_LO, 1'b1, 32'h0);
    wb(itc_pkg::ADR_POL_HI, 1'b1, 32'h0);
    closed <= 8'h00;
    settle(8'h00);
    $display("test polarity done");
    // a glitch of two ticks must not pass a four-tick filter
    wb(itc_pkg::ADR_FILT, 1'b1, 32'h4);
    closed[7] <= 1'b1;
    fork
      begin
        repeat (80) @(posedge clk_i);
        closed[7] <= 1'b0;
      end
    join_none
    lat(7, 480);
    cmp(64'(c), 64'd480);
    closed[7] <= 1'b1;
    lat(7, 480);
    cmp(64'(c >= 160 && c <= 250), 64'h1);
    $display("test filter done");
    wb(itc_pkg::ADR_FILT, 1'b1, 32'h0);
    wb(itc_pkg::ADR_DLY0, 1'b1, 32'd20);
    closed <= 8'h08;
    lat(3, 500);
    cmp(64'(c <= 90), 64'h1);
    closed <= 8'h09;
    lat(0, 2000);
    cmp(64'(c >= 800 && c <= 930), 64'h1);
    wb(itc_pkg::ADR_DLY0, 1'b1, 32'h0);
    closed <= 8'h00;
    settle(8'h00);
    $display("test delay done");
    for (int k = 0; k < 6; k++) begin
      v = (k == 0) ? 32'd49 : (k == 1) ? 32'd50 : $urandom_range(48);
      wb(itc_pkg::ADR_FUNC_LO, 1'b1, v << 12);
      closed <= 8'h04;
      settle(8'h04);
      cmp(64'(func_active_o), (v < 50) ? 64'h1 << v : 64'h0);
      closed <= 8'h00;
      settle(8'h00);
    end
    $display("test routing done");
    wb(itc_pkg::ADR_IRQ_MASK, 1'b1, 32'h4);
    wb(itc_pkg::ADR_IRQ_ST, 1'b0, 32'h0);
    wb(itc_pkg::ADR_GROUP, 1'b1, 32'h1);
    repeat (3) @(posedge clk_i);
    cmp(64'({motor_group_o, irq_o}), 64'h3);
    wb(itc_pkg::ADR_IRQ_ST, 1'b0, 32'h0);
    repeat (2) @(posedge clk_i);
    cmp(64'({q[2], irq_o}), 64'h2);
    wb(itc_pkg::ADR_IRQ_MASK, 1'b1, 32'h0);
    wb(itc_pkg::ADR_GROUP, 1'b1, 32'h0);
    repeat (3) @(posedge clk_i);
    cmp(64'({motor_group_o, irq_o}), 64'h0);
    wb(itc_pkg::ADR_IRQ_MASK, 1'b1, 32'h4);
    repeat (2) @(posedge clk_i);
    cmp(64'(irq_o), 64'h1);
    wb(itc_pkg::ADR_IRQ_ST, 1'b0, 32'h0);
    wb(itc_pkg::ADR_FUNC_LO, 1'b1, 32'd41 << 6);
    closed <= 8'h02;
    settle(8'h02);
    repeat (2) @(posedge clk_i);
    cmp(64'(motor_group_o), 64'h1);
    closed <= 8'h00;
    settle(8'h00);
    repeat (2) @(posedge clk_i);
    cmp(64'(motor_group_o), 64'h0);
    $display("test group done");
    // input 4 counts nothing, input 5 counts, input 6 clears the count
    wb(itc_pkg::ADR_FUNC_LO, 1'b1, 32'd25 << 24);
    wb(itc_pkg::ADR_FUNC_HI, 1'b1, 32'h699);
    wb(itc_pkg::ADR_SET_TGT, 1'b1, 32'd5);
    wb(itc_pkg::ADR_DES_TGT, 1'b1, 32'd3);
    wb(itc_pkg::ADR_IRQ_MASK, 1'b1, 32'h3);
    pulse(6);
    pulse(4);
    cmp(64'(count_save_o), 64'h0);
    for (int k = 1; k <= 7; k++) begin
      pulse(5);
      cmp(64'(count_save_o), 64'(exp_cnt(k, 5)));
      cmp(64'({set_hit, des_hit}), 64'({k >= 5, k == 3}));
    end
    cmp(64'(irq_o), 64'h1);
    wb(itc_pkg::ADR_IRQ_ST, 1'b0, 32'h0);
    cmp(64'(q[1:0]), 64'h3);
    $display("test counter done");
    v = $urandom;
    rst_cnt <= v;
    rst_vld <= 1'b1;
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rst_vld <= 1'b0;
    cmp(64'(count_save_o), 64'(v));
    wb(itc_pkg::ADR_COUNT, 1'b0, 32'h0);
    cmp(64'(q), 64'(v));
    $display("test retention done");
    end_sim();
  end
endmodule : tb_input_terminal_conditioning
`default_nettype wire
